// ==== pkg/fpc_pkg.sv ====
/*
 package of the fast ethernet pcs codec: code-groups, patterns,
 timing counts, state encodings and the 4b/5b lookups.
 assumes one 25 MHz clock; one line bit is handled per cycle.
*/
package fpc_pkg;

   // -----------------------------------------------------------
   // code-groups and patterns
   // -----------------------------------------------------------
   localparam logic [4:0] CG_IDLE = 5'h1f;
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0d;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_H = 5'h04;
   localparam logic [9:0] CG_PAIR_TR = 10'h1a7;
   localparam logic [9:0] CG_PAIR_II = 10'h3ff;
   localparam logic [14:0] CG_IDLE_JK = 15'h7f11;
   localparam logic [3:0] NIB_PRE = 4'h5;
   localparam logic [3:0] NIB_BAD = 4'he;

   // -----------------------------------------------------------
   // counts and timing
   // -----------------------------------------------------------
   localparam logic [2:0] DIV_LAST = 3'h4;
   localparam logic [3:0] SSD_WAIT = 4'h8;
   localparam logic [7:0] LOCK_RUN = 8'h3c;
   localparam logic [1:0] MAN_NIB_LAST = 2'h3;
   localparam logic SEED_MSB = 1'b1;
   localparam int HOLD_US = 722;
   localparam int CLK_MHZ = 25;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;

   // -----------------------------------------------------------
   // mlt-3 levels and state encodings
   // -----------------------------------------------------------
   localparam logic [1:0] MLT_ZERO = 2'h0;
   localparam logic [1:0] MLT_POS = 2'h1;
   localparam logic [1:0] MLT_NEG = 2'h3;

   typedef enum logic [1:0] {
      FPC_TX_IDLE = 2'h0,
      FPC_TX_SSD2 = 2'h1,
      FPC_TX_DATA = 2'h3,
      FPC_TX_ESD2 = 2'h2
   } fpc_tx_e;

   typedef enum logic [1:0] {
      FPC_RX_IDLE = 2'h0,
      FPC_RX_PKT = 2'h1,
      FPC_RX_BAD = 2'h3
   } fpc_rx_e;

   // -----------------------------------------------------------
   // lookups
   // -----------------------------------------------------------
   function automatic logic [4:0] fpc_enc(input logic [3:0] nib);
      logic [4:0] cg;
      cg = 5'h1e;
      unique case (nib)
         4'h0: cg = 5'h1e;
         4'h1: cg = 5'h09;
         4'h2: cg = 5'h14;
         4'h3: cg = 5'h15;
         4'h4: cg = 5'h0a;
         4'h5: cg = 5'h0b;
         4'h6: cg = 5'h0e;
         4'h7: cg = 5'h0f;
         4'h8: cg = 5'h12;
         4'h9: cg = 5'h13;
         4'ha: cg = 5'h16;
         4'hb: cg = 5'h17;
         4'hc: cg = 5'h1a;
         4'hd: cg = 5'h1b;
         4'he: cg = 5'h1c;
         4'hf: cg = 5'h1d;
      endcase
      return cg;
   endfunction

   // returns {valid, nibble}; anything but data is invalid
   function automatic logic [4:0] fpc_dec(input logic [4:0] cg);
      logic [4:0] r;
      r = {1'b0, cg[3:0]};
      case (cg)
         5'h1e: r = 5'h10;
         5'h09: r = 5'h11;
         5'h14: r = 5'h12;
         5'h15: r = 5'h13;
         5'h0a: r = 5'h14;
         5'h0b: r = 5'h15;
         5'h0e: r = 5'h16;
         5'h0f: r = 5'h17;
         5'h12: r = 5'h18;
         5'h13: r = 5'h19;
         5'h16: r = 5'h1a;
         5'h17: r = 5'h1b;
         5'h1a: r = 5'h1c;
         5'h1b: r = 5'h1d;
         5'h1c: r = 5'h1e;
         5'h1d: r = 5'h1f;
         default: r = {1'b0, cg[3:0]};
      endcase
      return r;
   endfunction

endpackage

// ==== hdl/fpc_tx_line.sv ====
/*
 transmit line coder: scrambler seeded from the phy address,
 nrzi encoder and mlt-3 encoder, one code bit per clock.
 assumes the code bit is presented every cycle by the encoder.
*/
`timescale 1ns/1ns
module fpc_tx_line (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] phy_addr,
   input wire logic code_bit,
   output logic [1:0] line_level
);

   typedef struct packed {
      logic seeded;
      logic [10:0] lfsr;
      logic nrzi;
      logic [1:0] phase;
      logic [1:0] level;
   } fpc_txl_s;

   fpc_txl_s st, next_st;
   logic key, scr;

   assign key = st.lfsr[10] ^ st.lfsr[8];
   assign scr = code_bit ^ key;

   always_comb begin
      next_st = st;
      if (!st.seeded) begin
         // seed loaded after reset release, never zero
         next_st.lfsr = {fpc_pkg::SEED_MSB, ~phy_addr, phy_addr};
         next_st.seeded = 1'b1;
      end else begin
         next_st.lfsr = {st.lfsr[9:0], key};
         next_st.nrzi = st.nrzi ^ scr;
         if (next_st.nrzi) begin
            next_st.phase = st.phase + 2'h1;
         end
      end
      unique case (next_st.phase)
         2'h1: next_st.level = fpc_pkg::MLT_POS;
         2'h3: next_st.level = fpc_pkg::MLT_NEG;
         default: next_st.level = fpc_pkg::MLT_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign line_level = st.level;

endmodule // fpc_tx_line

// ==== hdl/fpc_rx_line.sv ====
/*
 receive line decoder: mlt-3 to nrzi, nrzi to nrz, descrambler
 that locks on idle and watches that the lock holds.
 assumes one equalised level per clock from the front end.
*/
`timescale 1ns/1ns
module fpc_rx_line #(
   parameter int unsigned HOLD_CYCLES = fpc_pkg::HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] line_level,
   output logic nrz_bit,
   output logic locked
);

   typedef struct packed {
      logic [1:0] prev_level;
      logic prev_nrzi;
      logic [10:0] lfsr;
      logic [7:0] run;
      logic [15:0] hold;
      logic locked;
      logic bit_out;
   } fpc_rxl_s;

   fpc_rxl_s st, next_st;
   logic nrzi, scr, pred, plain;

   assign nrzi = line_level != st.prev_level;
   assign scr = nrzi ^ st.prev_nrzi;
   assign pred = st.lfsr[10] ^ st.lfsr[8];
   assign plain = scr ^ pred;

   always_comb begin
      next_st = st;
      next_st.prev_level = line_level;
      next_st.prev_nrzi = nrzi;
      next_st.bit_out = 1'b1;
      if (!st.locked) begin
         // idle is all ones, so the key shows through inverted
         next_st.lfsr = {st.lfsr[9:0], ~scr};
         next_st.hold = 16'h0000;
         if (pred == ~scr) begin
            next_st.run = st.run + 8'h01;
         end else begin
            next_st.run = 8'h00;
         end
         if (next_st.run == fpc_pkg::LOCK_RUN) begin
            next_st.locked = 1'b1;
            next_st.run = 8'h00;
         end
      end else begin
         next_st.lfsr = {st.lfsr[9:0], pred};
         next_st.bit_out = plain;
         if (!plain) begin
            next_st.run = 8'h00;
         end else if (st.run != fpc_pkg::LOCK_RUN) begin
            next_st.run = st.run + 8'h01;
         end
         // a run of idle ones restarts the watchdog
         if (next_st.run == fpc_pkg::LOCK_RUN) begin
            next_st.hold = 16'h0000;
         end else begin
            next_st.hold = st.hold + 16'h0001;
         end
         if (st.hold == HOLD_CYCLES[15:0]) begin
            next_st.locked = 1'b0;
            next_st.run = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign nrz_bit = st.bit_out;
   assign locked = st.locked;

endmodule // fpc_rx_line

// ==== hdl/fpc_codec.sv ====
/*
 fast ethernet pcs codec top: 4b/5b transmit encoder with
 delimiters and idle fill, receive code-group alignment and
 decoder, and the 10 Mb/s manchester receive path.
 assumes mac nibbles are exchanged on the tx_take and rx_strobe
 pulses, one code-group per five clocks, and that the front end
 delivers one line level or manchester half-bit per clock.
*/
`timescale 1ns/1ns
// Functional notes
// - data nibbles map to sixteen data code-groups
// - first preamble byte becomes J then K
// - remaining preamble and data nibbles get encoded
// - tx enable drop appends T then R
// - idle code-group sent whenever no packet
// - control code-groups in data flag receive error
// - scrambler seed derived from phy address
// - scrambled stream passes an nrzi encoder
// - nrzi output drives three-level mlt-3 stepping
// - mlt-3 to nrzi to nrz, then descrambler
// - descrambler locks using received idle stream
// - no 100 Mb/s transmit or receive until locked; 10 Mb/s receive does not wait for lock
// - watch lock, reacquire on idle if lost
// - align to code-groups, decode by table
// - idle then J/K yields preamble 0101 0101
// - packet ends on T/R or two idles
// - 10 Mb/s manchester decode into nibbles
// - bad start: error, nibble 1110 until idles
module fpc_codec #(
   parameter int unsigned HOLD_CYCLES = fpc_pkg::HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] phy_addr,
   input wire logic mode_10m,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   input wire logic tx_er,
   output logic tx_take,
   output logic [1:0] line_tx_level,
   input wire logic [1:0] line_rx_level,
   input wire logic man_rx,
   input wire logic man_valid,
   output logic rx_dv,
   output logic rx_er,
   output logic [3:0] rxd,
   output logic rx_strobe,
   output logic crs,
   output logic scr_locked
);

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed {
      logic [2:0] div;
      fpc_pkg::fpc_tx_e txs;
      logic [4:0] tx_grp;
      fpc_pkg::fpc_rx_e rxs;
      logic [14:0] rsr;
      logic [2:0] rbit;
      logic [3:0] zc;
      logic pre2;
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic rx_strobe;
      logic crs;
      logic mph;
      logic mhalf;
      logic mprev;
      logic mframe;
      logic [1:0] mcnt;
      logic [3:0] mnib;
   } fpc_codec_s;

   fpc_codec_s st, next_st;
   logic tick;
   logic tx_start;
   logic rx_bit;
   logic [14:0] sr;
   logic [4:0] dec_prev;
   logic group_end;
   logic [3:0] man_nib;

   // -----------------------------------------------------------
   // line coders
   // -----------------------------------------------------------
   fpc_tx_line u_tx_line (
      .ref_clk(ref_clk),
      .rst(rst),
      .phy_addr(phy_addr),
      .code_bit(st.tx_grp[4]),
      .line_level(line_tx_level)
   );

   fpc_rx_line #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_rx_line (
      .ref_clk(ref_clk),
      .rst(rst),
      .line_level(line_rx_level),
      .nrz_bit(rx_bit),
      .locked(scr_locked)
   );

   // -----------------------------------------------------------
   // shared decode
   // -----------------------------------------------------------
   assign tick = st.div == fpc_pkg::DIV_LAST;
   // packets start only once the far end is tracked
   assign tx_start = tx_en && scr_locked && !mode_10m;
   assign sr = {st.rsr[13:0], rx_bit};
   assign dec_prev = fpc_pkg::fpc_dec(sr[9:5]);
   assign group_end = st.rbit == fpc_pkg::DIV_LAST;
   assign man_nib = {man_rx, st.mnib[3:1]};
   assign tx_take = tick && tx_en &&
      (st.txs == fpc_pkg::FPC_TX_SSD2 ||
       st.txs == fpc_pkg::FPC_TX_DATA ||
       (st.txs == fpc_pkg::FPC_TX_IDLE && tx_start));

   always_comb begin
      next_st = st;
      next_st.rx_strobe = 1'b0;
      next_st.rsr = sr;

      // ---------------------------------------------------------
      // transmit encoder
      // ---------------------------------------------------------
      // one code-group per five clocks, sent msb first
      next_st.div = tick ? 3'h0 : st.div + 3'h1;
      if (tick) begin
         unique case (st.txs)
            fpc_pkg::FPC_TX_IDLE: begin
               if (tx_start) begin
                  // first preamble nibble is dropped for J
                  next_st.tx_grp = fpc_pkg::CG_J;
                  next_st.txs = fpc_pkg::FPC_TX_SSD2;
               end else begin
                  next_st.tx_grp = fpc_pkg::CG_IDLE;
               end
            end
            fpc_pkg::FPC_TX_SSD2: begin
               next_st.tx_grp = fpc_pkg::CG_K;
               next_st.txs = fpc_pkg::FPC_TX_DATA;
            end
            fpc_pkg::FPC_TX_DATA: begin
               if (!tx_en) begin
                  next_st.tx_grp = fpc_pkg::CG_T;
                  next_st.txs = fpc_pkg::FPC_TX_ESD2;
               end else if (tx_er) begin
                  next_st.tx_grp = fpc_pkg::CG_H;
               end else begin
                  next_st.tx_grp = fpc_pkg::fpc_enc(txd);
               end
            end
            fpc_pkg::FPC_TX_ESD2: begin
               next_st.tx_grp = fpc_pkg::CG_R;
               next_st.txs = fpc_pkg::FPC_TX_IDLE;
            end
         endcase
      end else begin
         // shifting in ones keeps a stray bit looking like idle
         next_st.tx_grp = {st.tx_grp[3:0], 1'b1};
      end

      // ---------------------------------------------------------
      // 100 Mb/s receive decoder
      // ---------------------------------------------------------
      if (mode_10m || !scr_locked) begin
         // nothing is delivered while the descrambler hunts
         next_st.rxs = fpc_pkg::FPC_RX_IDLE;
         next_st.zc = 4'h0;
         next_st.pre2 = 1'b0;
         next_st.rbit = 3'h0;
      end else begin
         unique case (st.rxs)
            fpc_pkg::FPC_RX_IDLE: begin
               next_st.rx_dv = 1'b0;
               next_st.rx_er = 1'b0;
               next_st.crs = 1'b0;
               if (sr == fpc_pkg::CG_IDLE_JK) begin
                  // J/K after idle fixes the group boundary here
                  next_st.rxs = fpc_pkg::FPC_RX_PKT;
                  next_st.rbit = 3'h0;
                  next_st.zc = 4'h0;
                  next_st.pre2 = 1'b1;
                  next_st.rxd = fpc_pkg::NIB_PRE;
                  next_st.rx_dv = 1'b1;
                  next_st.crs = 1'b1;
                  next_st.rx_strobe = 1'b1;
               end else if (st.zc != 4'h0) begin
                  next_st.zc = st.zc + 4'h1;
                  if (next_st.zc == fpc_pkg::SSD_WAIT) begin
                     // a zero arrived but no J/K completed
                     next_st.rxs = fpc_pkg::FPC_RX_BAD;
                     next_st.rbit = 3'h0;
                     next_st.zc = 4'h0;
                     next_st.crs = 1'b1;
                     next_st.rx_er = 1'b1;
                  end
               end else if (!rx_bit) begin
                  next_st.zc = 4'h1;
               end
            end
            fpc_pkg::FPC_RX_PKT: begin
               next_st.rbit = group_end ? 3'h0 : st.rbit + 3'h1;
               if (group_end) begin
                  if (sr[9:0] == fpc_pkg::CG_PAIR_TR ||
                      sr[9:0] == fpc_pkg::CG_PAIR_II) begin
                     next_st.rxs = fpc_pkg::FPC_RX_IDLE;
                     next_st.rx_dv = 1'b0;
                     next_st.rx_er = 1'b0;
                     next_st.crs = 1'b0;
                     next_st.pre2 = 1'b0;
                  end else if (st.pre2) begin
                     // the K group also reads as preamble
                     next_st.pre2 = 1'b0;
                     next_st.rxd = fpc_pkg::NIB_PRE;
                     next_st.rx_er = 1'b0;
                     next_st.rx_strobe = 1'b1;
                  end else begin
                     // output lags one group so T/R is never sent
                     next_st.rxd = dec_prev[3:0];
                     next_st.rx_er = ~dec_prev[4];
                     next_st.rx_dv = 1'b1;
                     next_st.rx_strobe = 1'b1;
                  end
               end
            end
            fpc_pkg::FPC_RX_BAD: begin
               next_st.rbit = group_end ? 3'h0 : st.rbit + 3'h1;
               if (sr[9:0] == fpc_pkg::CG_PAIR_II) begin
                  // idle run ends the false carrier at any phase
                  next_st.rxs = fpc_pkg::FPC_RX_IDLE;
                  next_st.rx_er = 1'b0;
                  next_st.crs = 1'b0;
               end else if (group_end) begin
                  next_st.rxd = fpc_pkg::NIB_BAD;
                  next_st.rx_er = 1'b1;
                  next_st.rx_dv = 1'b0;
                  next_st.rx_strobe = 1'b1;
               end
            end
            default: begin
               next_st.rxs = fpc_pkg::FPC_RX_IDLE;
            end
         endcase
         if (st.rxs != fpc_pkg::FPC_RX_IDLE &&
             next_st.rxs == fpc_pkg::FPC_RX_IDLE) begin
            next_st.zc = 4'h0;
         end
      end
      if (!mode_10m && !scr_locked) begin
         next_st.rx_dv = 1'b0;
         next_st.rx_er = 1'b0;
         next_st.crs = 1'b0;
      end

      // ---------------------------------------------------------
      // 10 Mb/s manchester receive
      // ---------------------------------------------------------
      // half-bits arrive one per clock; a one is low then high,
      // so the second half carries the bit value
      if (mode_10m) begin
         if (!man_valid) begin
            next_st.mph = 1'b0;
            next_st.mframe = 1'b0;
            next_st.mcnt = 2'h0;
            next_st.mprev = 1'b0;
            next_st.rx_dv = 1'b0;
            next_st.rx_er = 1'b0;
            next_st.crs = 1'b0;
         end else if (!st.mph) begin
            next_st.mph = 1'b1;
            next_st.mhalf = man_rx;
            next_st.crs = 1'b1;
         end else begin
            next_st.mph = 1'b0;
            next_st.mprev = man_rx;
            if (!st.mframe) begin
               // preamble alternates; the delimiter ends in 1 1
               if (st.mprev && man_rx && !st.mhalf) begin
                  next_st.mframe = 1'b1;
                  next_st.mcnt = 2'h0;
               end
            end else begin
               // nibbles go out least significant bit first
               next_st.mnib = man_nib;
               next_st.mcnt = st.mcnt + 2'h1;
               if (st.mcnt == fpc_pkg::MAN_NIB_LAST) begin
                  next_st.rxd = man_nib;
                  next_st.rx_dv = 1'b1;
                  // equal halves of the nibble's last bit mean a coding violation; earlier bits are not checked
                  next_st.rx_er = st.mhalf == man_rx;
                  next_st.rx_strobe = 1'b1;
               end
            end
         end
      end
   end

   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rx_dv = st.rx_dv;
   assign rx_er = st.rx_er;
   assign rxd = st.rxd;
   assign rx_strobe = st.rx_strobe;
   assign crs = st.crs;

endmodule // fpc_codec

// ==== dv/fpc_codec_chk_sva.sv ====
/*
 checker of the codec top ports: nibble pacing, delimiters, mlt-3.
 assumes it is bound to fpc_codec and sees one clock domain.
*/
`timescale 1ns/1ns
module fpc_codec_chk #(
   parameter int unsigned HOLD_CYCLES = fpc_pkg::HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] phy_addr,
   input wire logic mode_10m,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   input wire logic tx_er,
   input wire logic tx_take,
   input wire logic [1:0] line_tx_level,
   input wire logic [1:0] line_rx_level,
   input wire logic man_rx,
   input wire logic man_valid,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic [3:0] rxd,
   input wire logic rx_strobe,
   input wire logic crs,
   input wire logic scr_locked
);
   logic [1:0] last_nz;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // last non-zero level, so the 0,+,0,- cycle can be checked
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         last_nz <= fpc_pkg::MLT_ZERO;
      else if (line_tx_level != fpc_pkg::MLT_ZERO)
         last_nz <= line_tx_level;
   sequence s_tx_quiet;
      !tx_take [*4];
   endsequence
   sequence s_preamble;
      rx_strobe && rxd == fpc_pkg::NIB_PRE
      ##5 (!rx_dv || rx_strobe && rxd == fpc_pkg::NIB_PRE);
   endsequence
   AST_TAKE_PACE: assert property (tx_take |=> s_tx_quiet)
      else $error("tx_take closer than five cycles");
   AST_TAKE_LOCKED: assert property (
      tx_take |-> scr_locked && !mode_10m)
      else $error("nibble taken while unlocked");
   AST_END_GAP: assert property (
      tx_take ##5 !tx_take |-> ##1 !tx_take [*8])
      else $error("no end pair gap after packet");
   AST_MLT_ALT: assert property (
      $rose(line_tx_level != fpc_pkg::MLT_ZERO) &&
      last_nz != fpc_pkg::MLT_ZERO |-> line_tx_level ==
      (last_nz == fpc_pkg::MLT_POS ? fpc_pkg::MLT_NEG : fpc_pkg::MLT_POS))
      else $error("mlt-3 level out of order");
   AST_RX_IDLE: assert property (
      (!scr_locked && !mode_10m) [*2] |-> !rx_dv && !rx_strobe)
      else $error("receive data while unlocked");
   AST_PREAMBLE: assert property (
      $rose(rx_dv) && !mode_10m |-> s_preamble)
      else $error("start pair not given as two preamble nibbles");
   AST_RX_PACE: assert property (
      rx_strobe && rx_dv && !mode_10m
      |=> !rx_strobe [*4] ##1 (rx_strobe || !rx_dv))
      else $error("receive nibbles not one per code-group");
   AST_BAD_NIB: assert property (
      rx_strobe && rx_er && !rx_dv |-> rxd == fpc_pkg::NIB_BAD && crs)
      else $error("bad start nibble wrong");
   AST_MAN_PACE: assert property (
      rx_strobe && mode_10m |=> !rx_strobe [*7])
      else $error("10M nibbles closer than four bits");
endmodule // fpc_codec_chk

bind fpc_codec fpc_codec_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
   .ref_clk(ref_clk), .rst(rst), .phy_addr(phy_addr),
   .mode_10m(mode_10m), .tx_en(tx_en), .txd(txd), .tx_er(tx_er),
   .tx_take(tx_take), .line_tx_level(line_tx_level),
   .line_rx_level(line_rx_level), .man_rx(man_rx),
   .man_valid(man_valid), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
   .rx_strobe(rx_strobe), .crs(crs), .scr_locked(scr_locked)
);

// ==== dv/fpc_mac_model.sv ====
/*
 mac model: preamble and random nibbles handed over on tx_take,
 expected receive words noted. assumes the line is looped back.
*/
`timescale 1ns/1ns
module fpc_mac_model (
   input wire logic ref_clk,
   input wire logic tx_take,
   output logic tx_en,
   output logic [3:0] txd,
   output logic tx_er
);
   logic [4:0] exp_q[$];
   int seed = 32'h0000_1cee;
   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
      tx_er = 1'b0;
   end
   // tx_take is combinational, so the nibble must stand before it
   task automatic send(input int len, input int er_at);
      for (int i = 0; i < len + 2; i++) begin
         @(negedge ref_clk);
         tx_en = 1'b1;
         txd = (i < 2) ? fpc_pkg::NIB_PRE : 4'($random(seed));
         tx_er = (i == er_at) && (i >= 2);
         #1;
         while (tx_take !== 1'b1) begin
            @(negedge ref_clk);
            #1;
         end
         exp_q.push_back(tx_er ? {1'b1, fpc_pkg::CG_H[3:0]} : {1'b0, txd});
      end
      @(negedge ref_clk);
      tx_en = 1'b0;
      tx_er = 1'b0;
   endtask
endmodule // fpc_mac_model

// ==== dv/tb_top.sv ====
/*
 bench of the codec: line looped back, mac model on transmit,
 manchester driven here. assumes HOLD_CYCLES scaled down to 200.
*/
`timescale 1ns/1ns
module tb_top;
   localparam int unsigned HOLD = 200;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic mode_10m = 1'b0;
   logic man_rx = 1'b0;
   logic man_valid = 1'b0;
   logic cut = 1'b0;
   logic junk = 1'b0;
   logic mon_on = 1'b0;
   logic [4:0] phy_addr = 5'h01;
   logic [63:0] s1, s2;
   logic [3:0] txd, rxd, nib;
   logic [1:0] line_tx_level, line_rx_level;
   logic tx_en, tx_er, tx_take, rx_dv, rx_er, rx_strobe, crs, scr_locked;
   int err_total = 0;
   int checks_done = 0;
   int seed = 32'h0000_1cee;
   always #20 ref_clk = ~ref_clk;
   always @(negedge ref_clk) junk <= ~junk;
   // a cut loop sees a steady toggle, which descrambles to noise
   assign line_rx_level = cut ? {1'b0, junk} : line_tx_level;
   fpc_codec #(.HOLD_CYCLES(HOLD)) uut (
      .ref_clk(ref_clk), .rst(rst), .phy_addr(phy_addr),
      .mode_10m(mode_10m), .tx_en(tx_en), .txd(txd), .tx_er(tx_er),
      .tx_take(tx_take), .line_tx_level(line_tx_level),
      .line_rx_level(line_rx_level), .man_rx(man_rx),
      .man_valid(man_valid), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
      .rx_strobe(rx_strobe), .crs(crs), .scr_locked(scr_locked)
   );
   fpc_mac_model mac (.ref_clk(ref_clk), .tx_take(tx_take),
      .tx_en(tx_en), .txd(txd), .tx_er(tx_er));
   task automatic check_rx(input logic [4:0] got);
      logic [4:0] want;
      want = mac.exp_q.size() > 0 ? mac.exp_q.pop_front() : ~got;
      checks_done++;
      if (got !== want) begin
         err_total++;
         $display("MISMATCH %0t rx word %h want %h", $time, got, want);
      end
   endtask
   task automatic check_flag(input logic got, input logic want,
                             input string what);
      checks_done++;
      if (got !== want) begin
         err_total++;
         $display("MISMATCH %0t %s is %b", $time, what, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input logic [4:0] a);
      @(negedge ref_clk);
      rst = 1'b1;
      phy_addr = a;
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
   endtask
   task automatic capture(output logic [63:0] s);
      repeat (64) begin
         @(negedge ref_clk);
         s = {s[62:0], line_tx_level != 2'h0};
      end
   endtask
   task automatic wait_lock(input logic want);
      for (int i = 0; i < 400 && scr_locked !== want; i++)
         @(negedge ref_clk);
   endtask
   task automatic packet(input int len, input int er_at);
      mac.send(len, er_at);
      repeat (80) @(negedge ref_clk);
      check_flag(rx_dv, 1'b0, "rx_dv after end");
      check_flag(crs, 1'b0, "crs after end");
      check_flag(mac.exp_q.size() == 0, 1'b1, "nibbles back");
      $display("packet of %0d nibbles done", len);
   endtask
   task automatic send_man(input logic b);
      @(negedge ref_clk);
      man_valid = 1'b1;
      man_rx = ~b;
      @(negedge ref_clk);
      man_rx = b;
   endtask
   always @(negedge ref_clk)
      if (mon_on && rx_strobe === 1'b1 && rx_dv === 1'b1)
         check_rx({rx_er, rxd}); // word seen
   initial begin
      do_reset(5'h01);
      capture(s1);
      do_reset(5'h1e);
      mon_on = 1'b1;
      fork
         capture(s2);
         packet(1, 0); // tx_en stands before lock
      join
      check_flag(s1 !== s2, 1'b1, "idle streams differ");
      $display("seed test done");
      packet(24, 9); // halt inside data
      packet(6, 0);
      mon_on = 1'b0;
      cut = 1'b1;
      wait_lock(1'b0);
      check_flag(scr_locked, 1'b0, "lock with line cut");
      cut = 1'b0;
      wait_lock(1'b1);
      check_flag(scr_locked, 1'b1, "relock");
      repeat (80) @(negedge ref_clk);
      mon_on = 1'b1;
      packet(4, 2);
      $display("relock test done");
      mode_10m = 1'b1;
      for (int i = 0; i < 15; i++)
         send_man(i == 14 || i[0]);
      repeat (4) begin
         nib = 4'($random(seed));
         mac.exp_q.push_back({1'b0, nib});
         for (int j = 0; j < 4; j++)
            send_man(nib[j]); // lsb first
      end
      repeat (2) @(negedge ref_clk);
      man_valid = 1'b0;
      repeat (3) @(negedge ref_clk);
      check_flag(rx_dv, 1'b0, "10M rx_dv");
      check_flag(crs, 1'b0, "10M crs");
      check_flag(mac.exp_q.size() == 0, 1'b1, "10M nibbles");
      $display("10M test done");
      final_report();
   end
   initial begin
      repeat (20000) @(negedge ref_clk);
      err_total++;
      $display("MISMATCH %0t watchdog expired", $time);
      final_report();
   end
endmodule // tb_top
